// ---- hdl/ttxhp_pkg.sv ----
// ttxhp_pkg: constants for the tone transceiver host port
// assumes: one core clock at 10 MHz, host strobe sampled as a plain pin
package ttxhp_pkg;
   localparam int unsigned TTXHP_NIB_W = 4;
   localparam int unsigned TTXHP_SYNC_W = 2;
   // control bank a fields
   localparam int unsigned TTXHP_CA_BANK_BIT = 3;
   localparam int unsigned TTXHP_CA_DETEN_BIT = 1;
   localparam int unsigned TTXHP_CA_KEYEN_BIT = 0;
   // control bank b fields
   localparam int unsigned TTXHP_CB_FSEL_HI = 3;
   localparam int unsigned TTXHP_CB_FSEL_LO = 2;
   localparam int unsigned TTXHP_CB_PTEN_BIT = 1;
   // status fields
   localparam int unsigned TTXHP_ST_INVALID_BIT = 3;
   localparam int unsigned TTXHP_ST_DIGIT_BIT = 2;
   localparam int unsigned TTXHP_ST_PROG_BIT = 1;
   localparam int unsigned TTXHP_ST_ANY_BIT = 0;
   // reset values
   localparam logic [3:0] TTXHP_NIB_RST = 4'h0;
   localparam logic [3:0] TTXHP_STATUS_RST = 4'h8;
   typedef enum logic [2:0] {
      TTXHP_IDLE = 3'b001,
      TTXHP_READ = 3'b010,
      TTXHP_WRITE = 3'b100
   } ttxhp_state_t;
endpackage : ttxhp_pkg

// ---- hdl/ttxhp_sync.sv ----
// ttxhp_sync: two-flop synchroniser for a group of pin levels
// assumes: inputs are asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module ttxhp_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;
   always_comb begin
      meta_nxt = d;
      q_nxt = meta_r;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= meta_nxt;
         q <= q_nxt;
      end
   end
endmodule : ttxhp_sync
`default_nettype wire

// ---- hdl/ttxhp_top.sv ----
// ttxhp_top: nibble host port, control and status registers, detect outputs
// assumes: host strobe, select, address, direction and bus come from pins;
// detector and receiver events arrive from core logic on clk
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - write captures bus nibble at falling edge of the host strobe
// - read drives addressed register onto bus from strobe rising edge
// - strobe is aperiodic; only edges during transfers matter
// - transfers act only with active-low select at zero
// - group select one: write control, read status
// - group select zero: write transmit digit, read receive digit
// - direction one reads, zero writes; host holds it steady
// - power-down request high clears transmit digit, control registers and flags, blocks transfers and holds detect outputs low
// - progress detect output high while progress tone detected
// - special detect output high while special tone detected
// - progress detect high forces special detect output low
// - keypad tone output enabled only by host-written control bit
// - progress tone output enabled by host-written control bit
// - status nibble: invalid, digit flag, progress flag, any flag
// - status read clears the three flags after the read
// - bank bit redirects only the next control write to bank b
// - detect enable low holds both detect outputs low
module ttxhp_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host pins
   input wire logic host_strobe,
   input wire logic host_select_n,
   input wire logic register_group_select,
   input wire logic host_read_not_write,
   input wire logic [ttxhp_pkg::TTXHP_NIB_W-1:0] host_nibble_bus_in,
   output logic [ttxhp_pkg::TTXHP_NIB_W-1:0] host_nibble_bus_out,
   output logic host_nibble_bus_oe,
   input wire logic powerdown_request,
   // core events and receive data
   input wire logic [ttxhp_pkg::TTXHP_NIB_W-1:0] rx_digit,
   input wire logic rx_digit_valid,
   input wire logic rx_digit_event,
   input wire logic progress_tone_present,
   input wire logic special_tone_present,
   input wire logic progress_event,
   // outputs to tone generators and pins
   output logic [ttxhp_pkg::TTXHP_NIB_W-1:0] tx_digit,
   output logic keypad_tone_out,
   output logic progress_tone_out,
   output logic [1:0] progress_freq_sel,
   output logic progress_tone_detected,
   output logic special_tone_detected,
   output logic powered_down
);
   import ttxhp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [8:0] pin_raw;
   logic [8:0] pin_s;
   logic strobe_s, sel_n_s, grp_s, rd_s, pd_s;
   logic [3:0] bus_s;
   assign pin_raw = {powerdown_request, host_nibble_bus_in, host_read_not_write,
                     register_group_select, host_select_n, host_strobe};
   ttxhp_sync #(.W(9)) u_sync (
      .clk(clk),
      .rst(rst),
      .d(pin_raw),
      .q(pin_s)
   );
   assign strobe_s = pin_s[0];
   assign sel_n_s = pin_s[1];
   assign grp_s = pin_s[2];
   assign rd_s = pin_s[3];
   assign bus_s = pin_s[7:4];
   assign pd_s = pin_s[8];

   ////////////////////////////////////////////////////////////////////////
   // strobe edges and transfer state
   logic strobe_d_r, strobe_d_nxt;
   logic rise, fall;
   ttxhp_state_t state_r, state_nxt;
   // edge detection, no free-running strobe assumed
   assign rise = strobe_s & ~strobe_d_r;
   assign fall = ~strobe_s & strobe_d_r;
   always_comb begin
      strobe_d_nxt = strobe_s;
      state_nxt = state_r;
      case (state_r)
         TTXHP_IDLE: begin
            if (rise && !sel_n_s && !pd_s) begin
               state_nxt = rd_s ? TTXHP_READ : TTXHP_WRITE;
            end
         end
         TTXHP_READ: begin
            if (fall || sel_n_s || pd_s) begin
               state_nxt = TTXHP_IDLE;
            end
         end
         TTXHP_WRITE: begin
            if (fall || sel_n_s || pd_s) begin
               state_nxt = TTXHP_IDLE;
            end
         end
         default: state_nxt = TTXHP_IDLE;
      endcase
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strobe_d_r <= 1'b0;
         state_r <= TTXHP_IDLE;
      end else begin
         strobe_d_r <= strobe_d_nxt;
         state_r <= state_nxt;
      end
   end
   logic wr_fire, rd_done;
   // write lands on the falling strobe edge
   assign wr_fire = (state_r == TTXHP_WRITE) && fall && !sel_n_s && !pd_s;
   assign rd_done = (state_r == TTXHP_READ) && fall && !sel_n_s && !pd_s;

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [3:0] tx_r, tx_nxt, cra_r, cra_nxt, crb_r, crb_nxt;
   logic bank_b_r, bank_b_nxt;
   logic digit_flag_r, digit_flag_nxt, prog_flag_r, prog_flag_nxt;
   logic any_flag_r, any_flag_nxt;
   logic [3:0] status_w;
   logic [3:0] bus_out_nxt;
   logic bus_oe_nxt;
   logic cp_nxt, fx_nxt;
   assign status_w = {~rx_digit_valid, digit_flag_r, prog_flag_r, any_flag_r};
   always_comb begin
      tx_nxt = tx_r;
      cra_nxt = cra_r;
      crb_nxt = crb_r;
      bank_b_nxt = bank_b_r;
      digit_flag_nxt = digit_flag_r;
      prog_flag_nxt = prog_flag_r;
      any_flag_nxt = any_flag_r;
      // read clears flags; a new event in the same cycle wins
      if (rd_done && grp_s) begin
         digit_flag_nxt = 1'b0;
         prog_flag_nxt = 1'b0;
         any_flag_nxt = 1'b0;
      end
      if (rx_digit_event) begin
         digit_flag_nxt = 1'b1;
      end
      if (progress_event) begin
         prog_flag_nxt = 1'b1;
      end
      if (rx_digit_event || progress_event) begin
         any_flag_nxt = 1'b1;
      end
      if (wr_fire) begin
         if (grp_s) begin
            if (bank_b_r) begin
               crb_nxt = bus_s;
               bank_b_nxt = 1'b0;
            end else begin
               cra_nxt = bus_s;
               bank_b_nxt = bus_s[TTXHP_CA_BANK_BIT];
            end
         end else begin
            tx_nxt = bus_s;
         end
      end
      if (pd_s) begin
         tx_nxt = TTXHP_NIB_RST;
         cra_nxt = TTXHP_NIB_RST;
         crb_nxt = TTXHP_NIB_RST;
         bank_b_nxt = 1'b0;
         digit_flag_nxt = 1'b0;
         prog_flag_nxt = 1'b0;
         any_flag_nxt = 1'b0;
      end
      // drive from rising edge; group selects status
      bus_out_nxt = grp_s ? status_w : rx_digit;
      bus_oe_nxt = (state_nxt == TTXHP_READ);
      cp_nxt = progress_tone_present && cra_r[TTXHP_CA_DETEN_BIT] && !pd_s;
      // special detect blocked by progress detect
      fx_nxt = special_tone_present && !cp_nxt && cra_r[TTXHP_CA_DETEN_BIT] && !pd_s;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_r <= TTXHP_NIB_RST;
         cra_r <= TTXHP_NIB_RST;
         crb_r <= TTXHP_NIB_RST;
         bank_b_r <= 1'b0;
         digit_flag_r <= 1'b0;
         prog_flag_r <= 1'b0;
         any_flag_r <= 1'b0;
         host_nibble_bus_out <= TTXHP_NIB_RST;
         host_nibble_bus_oe <= 1'b0;
         progress_tone_detected <= 1'b0;
         special_tone_detected <= 1'b0;
         tx_digit <= TTXHP_NIB_RST;
         keypad_tone_out <= 1'b0;
         progress_tone_out <= 1'b0;
         progress_freq_sel <= 2'h0;
         powered_down <= 1'b0;
      end else begin
         tx_r <= tx_nxt;
         cra_r <= cra_nxt;
         crb_r <= crb_nxt;
         bank_b_r <= bank_b_nxt;
         digit_flag_r <= digit_flag_nxt;
         prog_flag_r <= prog_flag_nxt;
         any_flag_r <= any_flag_nxt;
         host_nibble_bus_out <= bus_out_nxt;
         host_nibble_bus_oe <= bus_oe_nxt;
         progress_tone_detected <= cp_nxt;
         special_tone_detected <= fx_nxt;
         tx_digit <= tx_nxt;
         // keypad tone only from control bit
         keypad_tone_out <= cra_nxt[TTXHP_CA_KEYEN_BIT];
         // progress tone from bank b bit
         progress_tone_out <= crb_nxt[TTXHP_CB_PTEN_BIT];
         progress_freq_sel <= crb_nxt[TTXHP_CB_FSEL_HI:TTXHP_CB_FSEL_LO];
         powered_down <= pd_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   // interlock
   AST_FX_INTERLOCK: assert property (@(posedge clk) disable iff (rst)
      progress_tone_detected |-> !special_tone_detected)
      else $error("special detect high with progress detect");
   AST_DET_DISABLED: assert property (@(posedge clk) disable iff (rst)
      !cra_r[TTXHP_CA_DETEN_BIT] |=> !progress_tone_detected && !special_tone_detected)
      else $error("detect output high while disabled");
   AST_BUS_RELEASE: assert property (@(posedge clk) disable iff (rst)
      host_nibble_bus_oe |-> state_r == TTXHP_READ && $past(!sel_n_s) && $past(!pd_s))
      else $error("bus driven outside a read");
   AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (rst)
      rd_done && grp_s && !rx_digit_event && !progress_event |=> !any_flag_r && !digit_flag_r && !prog_flag_r)
      else $error("flags survive status read");
   AST_BANK_ONESHOT: assert property (@(posedge clk) disable iff (rst)
      wr_fire && grp_s && bank_b_r |=> !bank_b_r && crb_r == $past(bus_s))
      else $error("bank b write not one-shot");
   AST_PD_CLEAR: assert property (@(posedge clk) disable iff (rst)
      pd_s |=> cra_r == TTXHP_NIB_RST && crb_r == TTXHP_NIB_RST && !any_flag_r)
      else $error("state not cleared in power-down");
   AST_ANY_FLAG: assert property (@(posedge clk) disable iff (rst)
      (digit_flag_r || prog_flag_r) |-> any_flag_r)
      else $error("any flag missing");
   AST_TX_WRITE: assert property (@(posedge clk) disable iff (rst)
      wr_fire && !grp_s && !pd_s |=> tx_digit == $past(bus_s))
      else $error("transmit digit not written");
endmodule : ttxhp_top
`default_nettype wire

// ---- verif/ttxhp_host_model.sv ----
// ttxhp_host_model: behavioural microcontroller on the nibble port
// assumes: the bench resolves the bus wire from both drivers and the pull-downs
`timescale 1ns/1ns
`default_nettype none
module ttxhp_host_model (
   // clock
   input wire logic clk,
   // host pins
   output logic strobe,
   output logic select_n,
   output logic group_sel,
   output logic read_nw,
   output logic [3:0] drive_d,
   output logic drive_oe,
   input wire logic [3:0] bus,
   // read result
   output logic rd_done,
   output logic [3:0] rd_data
);
   initial begin
      strobe = 1'h0;
      select_n = 1'h1;
      group_sel = 1'h0;
      read_nw = 1'h0;
      drive_d = 4'h0;
      drive_oe = 1'h0;
      rd_done = 1'h0;
      rd_data = 4'h0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // strobe high and low for 400 ns each, four clk periods, longer than the core needs to follow it
   task automatic xfer(input logic sn, input logic grp, input logic rnw, input logic [3:0] d);
      @(posedge clk);
      #1;
      select_n = sn;
      group_sel = grp;
      read_nw = rnw;
      drive_d = d;
      drive_oe = !rnw;
      @(posedge clk);
      #1;
      strobe = 1'h1;
      repeat (4) @(posedge clk);
      #1;
      rd_data = bus;
      rd_done = rnw && !sn;
      strobe = 1'h0;
      repeat (4) @(posedge clk);
      #1;
      rd_done = 1'h0;
      select_n = 1'h1;
      drive_oe = 1'h0;
   endtask : xfer
endmodule : ttxhp_host_model
`default_nettype wire

// ---- verif/ttxhp_top_tb.sv ----
// ttxhp_top_tb: self-checking bench for the nibble host port
// assumes: the host model drives the pins, the bench drives core-side events
`timescale 1ns/1ns
`default_nettype none
module ttxhp_top_tb;
   import ttxhp_pkg::*;
   logic clk, rst, host_strobe, host_select_n, register_group_select, host_read_not_write;
   logic powerdown_request, rx_digit_valid, rx_digit_event, progress_tone_present, special_tone_present;
   logic progress_event, host_nibble_bus_oe, keypad_tone_out, progress_tone_out, progress_tone_detected;
   logic special_tone_detected, powered_down, drive_oe, rd_done;
   logic [3:0] host_nibble_bus_in, host_nibble_bus_out, rx_digit, tx_digit, drive_d, rd_data;
   logic [1:0] progress_freq_sel;
   logic [3:0] exp_q[$];
   logic [31:0] lfsr;
   int n_fail;
   int checked;
   // pins are pulled down when nobody drives them
   assign host_nibble_bus_in = host_nibble_bus_oe ? host_nibble_bus_out : (drive_oe ? drive_d : 4'h0);
   ttxhp_top dut (.clk, .rst, .host_strobe, .host_select_n, .register_group_select, .host_read_not_write,
      .host_nibble_bus_in, .host_nibble_bus_out, .host_nibble_bus_oe, .powerdown_request, .rx_digit,
      .rx_digit_valid, .rx_digit_event, .progress_tone_present, .special_tone_present, .progress_event,
      .tx_digit, .keypad_tone_out, .progress_tone_out, .progress_freq_sel, .progress_tone_detected,
      .special_tone_detected, .powered_down);
   ttxhp_host_model host (.clk, .strobe(host_strobe), .select_n(host_select_n),
      .group_sel(register_group_select), .read_nw(host_read_not_write), .drive_d, .drive_oe,
      .bus(host_nibble_bus_in), .rd_done, .rd_data);
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tk
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // settle covers sync, register update and output lag after the fall
   task automatic wr(input logic grp, input logic [3:0] d);
      host.xfer(1'h0, grp, 1'h0, d);
      tk(2);
   endtask : wr
   task automatic rd(input logic grp, input logic [3:0] e);
      exp_q.push_back(e);
      host.xfer(1'h0, grp, 1'h1, 4'h0);
   endtask : rd
   task automatic print_verdict;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge rd_done) begin
      if (exp_q.size() == 0) begin
         n_fail++;
         $display("CHECK FAILED at %0t: read result with no expectation", $time);
      end else begin
         chk(rd_data, exp_q.pop_front());
      end
   end
   initial begin
      #1000000;
      n_fail++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      print_verdict();
   end
   initial begin
      rst = 1'h1;
      powerdown_request = 1'h0;
      rx_digit = 4'h0;
      rx_digit_valid = 1'h0;
      rx_digit_event = 1'h0;
      progress_tone_present = 1'h0;
      special_tone_present = 1'h0;
      progress_event = 1'h0;
      lfsr = 32'h27FBADE2;
      n_fail = 0;
      checked = 0;
      tk(10);
      rst = 1'h0;
      tk(3);
      chk({keypad_tone_out, progress_tone_out, progress_tone_detected, tx_digit[0]}, 4'h0);
      repeat (4) begin
         lfsr = lfsr_next(lfsr);
         wr(1'h0, lfsr[3:0]);
         chk(tx_digit, lfsr[3:0]);
      end
      host.xfer(1'h1, 1'h0, 1'h0, ~lfsr[3:0]);
      tk(2);
      chk(tx_digit, lfsr[3:0]);
      rd(1'h1, TTXHP_STATUS_RST);
      rx_digit = lfsr[7:4];
      rx_digit_valid = 1'h1;
      rd(1'h0, lfsr[7:4]);
      rx_digit_event = 1'h1;
      tk(1);
      rx_digit_event = 1'h0;
      rd(1'h1, 4'h5);
      rd(1'h1, 4'h0);
      progress_event = 1'h1;
      tk(1);
      progress_event = 1'h0;
      rd(1'h1, 4'h3);
      rd(1'h1, 4'h0);
      chk({3'h0, host_nibble_bus_oe}, 4'h0);
      wr(1'h1, 4'hB);
      chk({3'h0, keypad_tone_out}, 4'h1);
      progress_tone_present = 1'h1;
      special_tone_present = 1'h1;
      tk(3);
      chk({2'h0, progress_tone_detected, special_tone_detected}, 4'h2);
      progress_tone_present = 1'h0;
      tk(3);
      chk({2'h0, progress_tone_detected, special_tone_detected}, 4'h1);
      wr(1'h1, 4'hE);
      chk({keypad_tone_out, progress_tone_out, progress_freq_sel}, 4'hF);
      wr(1'h1, 4'h0);
      chk({keypad_tone_out, progress_tone_out, progress_freq_sel}, 4'h7);
      tk(3);
      chk({2'h0, progress_tone_detected, special_tone_detected}, 4'h0);
      powerdown_request = 1'h1;
      tk(5);
      chk({powered_down, progress_tone_out, tx_digit[1:0]}, 4'h8);
      wr(1'h0, 4'h5);
      chk(tx_digit, 4'h0);
      powerdown_request = 1'h0;
      tk(5);
      wr(1'h0, 4'h9);
      chk(tx_digit, 4'h9);
      rst = 1'h1;
      tk(2);
      rst = 1'h0;
      tk(3);
      chk(tx_digit, 4'h0);
      if (exp_q.size() != 0) begin
         n_fail++;
         $display("CHECK FAILED at %0t: reads missing", $time);
      end
      print_verdict();
   end
endmodule : ttxhp_top_tb
`default_nettype wire
